// >>> lpc_ctrl.v
// low-power clock mode controller with apb register access
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "lpc_defs.vh"
module lpc_ctrl (
    // clock and reset
    input wire mclk,
    input wire rst_n,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // asynchronous wake-up request
    input wire wake_irq,
    // oscillator and clock enables
    output reg main_osc_en,
    output reg sub_osc_en,
    output reg pll_en,
    output reg [3:0] pll_mult,
    output reg [1:0] mach_src,
    output reg cpu_clk_en,
    output reg periph_clk_en,
    output reg tbt_clk_en,
    output reg wdt_watch_clk_en,
    output reg [3:0] mode
);

// mode encodings, also the mode output
localparam M_PLL = 4'h0;
localparam M_PLL_SLEEP = 4'h1;
localparam M_PLL_WATCH = 4'h2;
localparam M_PWATCH = 4'h3;
localparam M_MAIN = 4'h4;
localparam M_MAIN_SLEEP = 4'h5;
localparam M_MAIN_WATCH = 4'h6;
localparam M_MAIN_STOP = 4'h7;
localparam M_SUB = 4'h8;
localparam M_SUB_SLEEP = 4'h9;
localparam M_SUB_WATCH = 4'hA;
localparam M_SUB_STOP = 4'hB;
localparam M_PLL_WAIT = 4'hC;
localparam M_MAIN_WAIT = 4'hD;
localparam M_PLL_EXIT = 4'hE;
// machine clock source
localparam SRC_MAIN = 2'h0;
localparam SRC_SUB = 2'h1;
localparam SRC_PLL = 2'h2;

reg [7:0] clksel_q;
reg [2:0] req_q;
reg [3:0] st_q;
reg [3:0] st_d;
reg [3:0] home_q;
reg [15:0] cnt_q;
reg [3:0] sync_q;
reg [2:0] idiv_q;
reg wake_s1_q;
reg wake_s2_q;
reg pll_lock_q;
reg main_wait_q;

wire main_sel = clksel_q[`LPC_BIT_MAIN_SEL];
wire sub_sel = clksel_q[`LPC_BIT_SUB_SEL];
wire [1:0] mult_code = {clksel_q[`LPC_BIT_MULT_HI], clksel_q[`LPC_BIT_MULT_LO]};
wire [1:0] wait_code = {clksel_q[`LPC_BIT_WAIT_HI], clksel_q[`LPC_BIT_WAIT_LO]};
wire intermit = clksel_q[`LPC_BIT_INTERMIT];
wire wr = psel && penable && pwrite;
wire rd = psel && !penable && !pwrite;
wire map_hit = (paddr == `LPC_OFS_CLKSEL) || (paddr == `LPC_OFS_MODE) ||
    (paddr == `LPC_OFS_STATUS);
wire cnt_done = (cnt_q == 16'h0000);
wire sync_pt = (sync_q == 4'h0);
wire wake = wake_s2_q;

reg [15:0] main_wait_len;
always @* begin
    case (wait_code)
        2'h0: main_wait_len = `LPC_MWAIT_0;
        2'h1: main_wait_len = `LPC_MWAIT_1;
        2'h2: main_wait_len = `LPC_MWAIT_2;
        default: main_wait_len = `LPC_MWAIT_3;
    endcase
end

// wake request is asynchronous to mclk
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        wake_s1_q <= 1'b0;
        wake_s2_q <= 1'b0;
    end else begin
        wake_s1_q <= wake_irq;
        wake_s2_q <= wake_s1_q;
    end
end

// mode transitions
always @* begin
    st_d = st_q;
    case (st_q)
        M_MAIN: begin
            if (!main_sel && sub_sel)
                st_d = M_PLL_WAIT;
            else if (!sub_sel)
                st_d = M_SUB;
            else if (req_q == `LPC_REQ_SLEEP)
                st_d = M_MAIN_SLEEP;
            else if (req_q == `LPC_REQ_WATCH)
                st_d = M_MAIN_WATCH;
            else if (req_q == `LPC_REQ_PWATCH)
                st_d = M_PWATCH;
            else if (req_q == `LPC_REQ_STOP)
                st_d = M_MAIN_STOP;
        end
        M_PLL_WAIT: begin
            if (main_sel || !sub_sel)
                st_d = M_MAIN;
            else if (cnt_done)
                st_d = M_PLL;
        end
        M_PLL: begin
            if (main_sel || !sub_sel)
                st_d = M_PLL_EXIT;
            else if (req_q == `LPC_REQ_SLEEP)
                st_d = M_PLL_SLEEP;
            else if (req_q == `LPC_REQ_WATCH)
                st_d = M_PLL_WATCH;
            else if (req_q == `LPC_REQ_PWATCH)
                st_d = M_PWATCH;
            else if (req_q == `LPC_REQ_STOP)
                st_d = M_MAIN_STOP;
        end
        M_PLL_EXIT: begin
            if (sync_pt)
                st_d = sub_sel ? M_MAIN : M_SUB;
        end
        M_SUB: begin
            if (sub_sel)
                st_d = M_MAIN_WAIT;
            else if (req_q == `LPC_REQ_SLEEP)
                st_d = M_SUB_SLEEP;
            else if (req_q == `LPC_REQ_WATCH || req_q == `LPC_REQ_PWATCH)
                st_d = M_SUB_WATCH;
            else if (req_q == `LPC_REQ_STOP)
                st_d = M_SUB_STOP;
        end
        M_MAIN_WAIT: begin
            if (cnt_done)
                st_d = main_sel ? home_q : M_PLL_WAIT;
        end
        M_PLL_SLEEP, M_PLL_WATCH, M_PWATCH, M_MAIN_SLEEP, M_MAIN_WATCH,
        M_SUB_SLEEP, M_SUB_WATCH: begin
            if (wake)
                st_d = home_q;
        end
        M_MAIN_STOP: begin
            if (wake)
                st_d = M_MAIN_WAIT;
        end
        M_SUB_STOP: begin
            if (wake)
                st_d = M_SUB;
        end
        default: st_d = M_MAIN;
    endcase
end

always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        st_q <= M_MAIN;
        home_q <= M_MAIN;
        cnt_q <= 16'h0000;
        main_wait_q <= 1'b0;
    end else begin
        st_q <= st_d;
        // remember which clock mode a sleep or watch returns to
        if (st_q == M_PLL || st_q == M_MAIN || st_q == M_SUB)
            home_q <= (st_q == M_PLL && st_d == M_MAIN_STOP) ? M_MAIN : st_q;
        else if (st_q == M_SUB && st_d == M_MAIN_WAIT)
            home_q <= M_MAIN;
        if (st_d == M_MAIN_WAIT && st_q != M_MAIN_WAIT)
            home_q <= M_MAIN;
        if (st_d == M_PLL_WAIT && st_q != M_PLL_WAIT)
            cnt_q <= `LPC_PLL_WAIT;
        else if (st_d == M_MAIN_WAIT && st_q != M_MAIN_WAIT)
            cnt_q <= main_wait_len;
        else if (!cnt_done)
            cnt_q <= cnt_q - 16'h0001;
        main_wait_q <= (st_d == M_MAIN_WAIT);
    end
end

// phase counter marking the point where pll and main edges line up
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        sync_q <= 4'h0;
        idiv_q <= 3'h0;
    end else begin
        if (sync_q == `LPC_SYNC_PERIOD - 4'h1)
            sync_q <= 4'h0;
        else
            sync_q <= sync_q + 4'h1;
        if (idiv_q == `LPC_INTERMIT_DIV - 3'h1)
            idiv_q <= 3'h0;
        else
            idiv_q <= idiv_q + 3'h1;
    end
end

// apb registers; the low-power request self-clears once a mode is taken
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        clksel_q <= `LPC_RST_CLKSEL;
        req_q <= `LPC_REQ_NONE;
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else begin
        pready <= psel && !penable;
        pslverr <= psel && !penable && !map_hit;
        if (wr && paddr == `LPC_OFS_CLKSEL)
            clksel_q <= pwdata[7:0];
        if (wr && paddr == `LPC_OFS_MODE)
            req_q <= pwdata[2:0];
        else if (st_q != st_d)
            req_q <= `LPC_REQ_NONE;
        if (rd) begin
            case (paddr)
                `LPC_OFS_CLKSEL: prdata <= {24'h000000, clksel_q};
                `LPC_OFS_MODE: prdata <= {29'h0, req_q};
                `LPC_OFS_STATUS: prdata <= {22'h0, pll_lock_q, main_wait_q, st_q,
                    home_q};
                default: prdata <= 32'h00000000;
            endcase
        end
    end
end

// clock enables per mode
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        main_osc_en <= 1'b1;
        sub_osc_en <= 1'b1;
        pll_en <= 1'b0;
        pll_mult <= 4'h2;
        mach_src <= SRC_MAIN;
        cpu_clk_en <= 1'b1;
        periph_clk_en <= 1'b1;
        tbt_clk_en <= 1'b1;
        wdt_watch_clk_en <= 1'b1;
        mode <= M_MAIN;
        pll_lock_q <= 1'b0;
    end else begin
        mode <= st_d;
        pll_mult <= {mult_code, 1'b0} + 4'h2;
        sub_osc_en <= (st_d != M_MAIN_STOP) && (st_d != M_SUB_STOP);
        pll_en <= (st_d == M_PLL) || (st_d == M_PLL_SLEEP) || (st_d == M_PLL_WAIT) ||
            (st_d == M_PLL_EXIT) || (st_d == M_PWATCH && home_q == M_PLL);
        pll_lock_q <= (st_d == M_PLL) || (st_d == M_PLL_SLEEP) || (st_d == M_PLL_EXIT);
        main_osc_en <= (st_d == M_PLL) || (st_d == M_PLL_SLEEP) || (st_d == M_PLL_WAIT) ||
            (st_d == M_PLL_EXIT) || (st_d == M_MAIN) || (st_d == M_MAIN_SLEEP) ||
            (st_d == M_MAIN_WAIT) || (st_d == M_PWATCH);
        // pll output halved downstream; main source is main/2
        case (st_d)
            M_PLL, M_PLL_SLEEP, M_PLL_EXIT: mach_src <= SRC_PLL;
            M_SUB, M_SUB_SLEEP, M_SUB_WATCH, M_SUB_STOP, M_PLL_WATCH,
            M_MAIN_WATCH: mach_src <= SRC_SUB;
            M_MAIN_WAIT: mach_src <= mach_src;
            default: mach_src <= SRC_MAIN; // pll wait keeps main
        endcase
        // cpu stops in every mode but pll, main, sub, pll wait and pll exit; intermittent gating
        cpu_clk_en <= (st_d == M_PLL || st_d == M_MAIN || st_d == M_SUB ||
            st_d == M_PLL_EXIT || st_d == M_PLL_WAIT) &&
            (!intermit || idiv_q == 3'h0);
        // peripherals keep full speed while cpu is intermittent
        periph_clk_en <= (st_d == M_PLL || st_d == M_MAIN || st_d == M_SUB ||
            st_d == M_PLL_EXIT || st_d == M_PLL_WAIT || st_d == M_PLL_SLEEP ||
            st_d == M_MAIN_SLEEP || st_d == M_SUB_SLEEP);
        // timebase follows the main oscillator, watch timer the sub one
        tbt_clk_en <= (st_d == M_PLL || st_d == M_PLL_SLEEP || st_d == M_PLL_WAIT ||
            st_d == M_PLL_EXIT || st_d == M_MAIN || st_d == M_MAIN_SLEEP ||
            st_d == M_MAIN_WAIT || st_d == M_PWATCH);
        wdt_watch_clk_en <= (st_d != M_MAIN_STOP) && (st_d != M_SUB_STOP);
    end
end

endmodule
`default_nettype wire

// >>> lpc_defs.vh
// constants for the low-power clock mode controller
`ifndef LPC_DEFS_VH
`define LPC_DEFS_VH
// register byte offsets
`define LPC_OFS_CLKSEL 12'h000
`define LPC_OFS_MODE 12'h004
`define LPC_OFS_STATUS 12'h008
// clock select register fields
`define LPC_BIT_MULT_LO 0
`define LPC_BIT_MULT_HI 1
`define LPC_BIT_WAIT_LO 2
`define LPC_BIT_WAIT_HI 3
`define LPC_BIT_SUB_SEL 4
`define LPC_BIT_MAIN_SEL 5
`define LPC_BIT_INTERMIT 6
// reset values: main clock selected, sub clock select set
`define LPC_RST_CLKSEL 8'h34
// low-power request codes in the mode register
`define LPC_REQ_NONE 3'h0
`define LPC_REQ_SLEEP 3'h1
`define LPC_REQ_WATCH 3'h2
`define LPC_REQ_PWATCH 3'h3
`define LPC_REQ_STOP 3'h4
// stabilization waits, in mclk cycles
`define LPC_PLL_WAIT 16'h0100
`define LPC_MWAIT_0 16'h0040
`define LPC_MWAIT_1 16'h0200
`define LPC_MWAIT_2 16'h1000
`define LPC_MWAIT_3 16'h4000
// main clock to PLL phase relation repeats every this many cycles
`define LPC_SYNC_PERIOD 4'h8
// intermittent CPU clock: one enable in this many cycles
`define LPC_INTERMIT_DIV 3'h4
`endif

// >>> lpc_ctrl_asserts.sv
// assertion checker for the low-power clock mode controller
`timescale 1ns/1ps
`default_nettype none
module lpc_ctrl_chk (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // clock control outputs
    input wire logic main_osc_en,
    input wire logic sub_osc_en,
    input wire logic pll_en,
    input wire logic [3:0] pll_mult,
    input wire logic [1:0] mach_src,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic tbt_clk_en,
    input wire logic wdt_watch_clk_en,
    input wire logic [3:0] mode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // enables change on the same edge as the mode code; only mid-mode samples are judged
    a_main_mode_clocks: assert property ((mode == 4'h4) [*3] |-> $past(main_osc_en)
        && $past(sub_osc_en) && !$past(pll_en) && $past(mach_src) == 2'h0) else $error("main clocks");
    a_sleep_gates_cpu: assert property ((mode == 4'h5) [*3] |-> !$past(cpu_clk_en)
        && $past(periph_clk_en) && $past(main_osc_en)) else $error("sleep clocks");
    a_pseudo_watch_run: assert property ((mode == 4'h3) [*3] |-> $past(tbt_clk_en)
        && $past(wdt_watch_clk_en) && !$past(cpu_clk_en) && !$past(periph_clk_en))
        else $error("pseudo-watch clocks");
    a_watch_only_timer: assert property ((mode inside {4'h2, 4'h6, 4'hA}) [*3] |->
        $past(wdt_watch_clk_en) && !$past(tbt_clk_en) && !$past(main_osc_en) && !$past(pll_en))
        else $error("watch clocks");
    a_stop_halts_osc: assert property ((mode inside {4'h7, 4'hB}) [*3] |->
        !$past(main_osc_en) && !$past(pll_en) && !$past(cpu_clk_en)) else $error("stop clocks");
    a_pll_mult_legal: assert property (pll_mult inside {4'h2, 4'h4, 4'h6, 4'h8})
        else $error("pll multiplier");
    a_sub_watch_wake: assert property ($past(mode) == 4'hA && mode != 4'hA |-> mode == 4'h8)
        else $error("sub watch wake");
    a_sub_stop_wake: assert property ($past(mode) == 4'hB && mode != 4'hB |-> mode == 4'h8)
        else $error("sub stop wake");
    a_pll_exit_dest: assert property (
        $past(mode) == 4'hE && mode != 4'hE |-> mode inside {4'h4, 4'h8}) else $error("pll exit");
    c_pll_mode: cover property (mode == 4'h0);
    c_sub_stop: cover property (mode == 4'hB);
    c_pseudo_watch: cover property (mode == 4'h3);
endmodule
bind lpc_ctrl lpc_ctrl_chk lpc_ctrl_chk_i (.mclk(mclk), .rst_n(rst_n), .main_osc_en(main_osc_en),
    .sub_osc_en(sub_osc_en), .pll_en(pll_en), .pll_mult(pll_mult), .mach_src(mach_src),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .tbt_clk_en(tbt_clk_en),
    .wdt_watch_clk_en(wdt_watch_clk_en), .mode(mode));
`default_nettype wire

// >>> lpc_ctrl_test.sv
// self-checking bench for the low-power clock mode controller
`timescale 1ns/1ps
`default_nettype none
`include "lpc_defs.vh"
module lpc_ctrl_test;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic wake_irq = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, main_osc_en, sub_osc_en, pll_en;
    logic cpu_clk_en, periph_clk_en, tbt_clk_en, wdt_watch_clk_en;
    logic [3:0] pll_mult, mode;
    logic [1:0] mach_src;
    integer n_fail = 0;
    integer checked = 0;
    always #5 mclk = ~mclk;
    lpc_ctrl lpc_ctrl_i (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wake_irq(wake_irq), .main_osc_en(main_osc_en),
        .sub_osc_en(sub_osc_en), .pll_en(pll_en), .pll_mult(pll_mult), .mach_src(mach_src),
        .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .tbt_clk_en(tbt_clk_en),
        .wdt_watch_clk_en(wdt_watch_clk_en), .mode(mode));
    task results;
        begin
            $display("checked %0d n_fail %0d", checked, n_fail);
            if (n_fail == 0 && checked > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("[ERR] %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    // one apb transfer; read data lands in rd and the error flag in err
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        integer n;
        begin
            @(posedge mclk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge mclk);
            penable <= 1'b1;
            n = 0;
            do begin
                @(posedge mclk);
                n = n + 1;
            end while (pready !== 1'b1 && n < 16);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            chk("pready", 32'h1, {31'h0, pready});
            if (pready !== 1'b1)
                results;
        end
    endtask
    // stabilization waits run to thousands of cycles, hence the generous bound
    task wait_mode(input logic [3:0] m);
        integer n;
        begin
            n = 0;
            while (mode !== m && n < 40000) begin
                @(posedge mclk);
                n = n + 1;
            end
            chk("mode", {28'h0, m}, {28'h0, mode});
            if (mode !== m)
                results;
        end
    endtask
    task lowp(input logic [2:0] req, input logic [3:0] lp, input logic [3:0] home);
        begin
            apb(`LPC_OFS_MODE, 1'b1, {29'h0, req});
            wait_mode(lp);
            repeat (2) @(posedge mclk);
            chk("cpu_clk_en", 32'h0, {31'h0, cpu_clk_en});
            wake_irq <= 1'b1;
            wait_mode(home);
            wake_irq <= 1'b0;
        end
    endtask
    task t_reset;
        begin
            chk("mach_src", 32'h0, {30'h0, mach_src});
            chk("pll_en", 32'h0, {31'h0, pll_en});
            chk("tbt_clk_en", 32'h1, {31'h0, tbt_clk_en});
            apb(12'h010, 1'b1, 32'hFFFF_FFFF);
            chk("slverr", 32'h1, {31'h0, err});
            apb(`LPC_OFS_CLKSEL, 1'b0, 32'h0);
            chk("clksel", 32'h34, rd);
            apb(12'h00C, 1'b0, 32'h0);
            chk("unmapped", 32'h1, {rd[30:0], err});
            apb(`LPC_OFS_STATUS, 1'b0, 32'h0);
            chk("status mode", 32'h4, {28'h0, rd[7:4]});
        end
    endtask
    task t_intermit;
        integer k, hi;
        begin
            apb(`LPC_OFS_CLKSEL, 1'b1, 32'h74);
            repeat (2) @(posedge mclk);
            hi = 0;
            for (k = 0; k < 8; k = k + 1) begin
                @(posedge mclk);
                hi = hi + cpu_clk_en + periph_clk_en;
            end
            chk("clock enables", 8 + 8 / `LPC_INTERMIT_DIV, hi);
            apb(`LPC_OFS_CLKSEL, 1'b1, 32'h34);
        end
    endtask
    task t_pll;
        integer c;
        begin
            for (c = 0; c < 4; c = c + 1) begin
                apb(`LPC_OFS_CLKSEL, 1'b1, 32'h14 | c);
                wait_mode(4'hC);
                chk("mach_src", 32'h0, {30'h0, mach_src});
                wait_mode(4'h0);
                chk("pll_mult", 2 * c + 2, {28'h0, pll_mult});
                chk("mach_src", 32'h2, {30'h0, mach_src});
                chk("pll_en", 32'h1, {31'h0, pll_en});
                apb(`LPC_OFS_CLKSEL, 1'b1, c == 3 ? 32'h4 : 32'h34);
                wait_mode(c == 3 ? 4'h8 : 4'h4);
            end
        end
    endtask
    task t_sub;
        integer n;
        begin
            chk("main_osc_en", 32'h0, {31'h0, main_osc_en});
            chk("mach_src", 32'h1, {30'h0, mach_src});
            chk("sub_osc_en", 32'h1, {31'h0, sub_osc_en});
            chk("wdt_watch_clk_en", 32'h1, {31'h0, wdt_watch_clk_en});
            lowp(3'h4, 4'hB, 4'h8);
            lowp(3'h2, 4'hA, 4'h8);
            apb(`LPC_OFS_CLKSEL, 1'b1, 32'h14);
            wait_mode(4'hD);
            n = 0;
            while (mode === 4'hD && n < 20000) begin
                @(posedge mclk);
                n = n + 1;
            end
            chk("main wait", 32'h1, {31'h0, n >= `LPC_MWAIT_1});
            wait_mode(4'h0);
            apb(`LPC_OFS_CLKSEL, 1'b1, 32'h34);
            wait_mode(4'h4);
        end
    endtask
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset;
        t_intermit;
        lowp(3'h1, 4'h5, 4'h4);
        lowp(3'h2, 4'h6, 4'h4);
        lowp(3'h3, 4'h3, 4'h4);
        lowp(3'h4, 4'h7, 4'h4);
        t_pll;
        t_sub;
        results;
    end
endmodule
`default_nettype wire
